/* File: include/smc_pkg.sv */
/*
  Shared constants and carrier types for the manual SCSI control and
  microcode store port. Assumes a byte-wide register port decoded by the
  enclosing chip.
*/
package smc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_TEST0 = 8'h18;
  localparam logic [7:0] OFS_FLAGS  = 8'h19;
  localparam logic [7:0] OFS_LINES0 = 8'h1A;
  localparam logic [7:0] OFS_LINES1 = 8'h1C;
  localparam logic [7:0] OFS_SCLO   = 8'h1E;
  localparam logic [7:0] OFS_SCHI   = 8'h20;
  localparam logic [7:0] OFS_UADDR  = 8'h22;
  localparam logic [7:0] OFS_PRT0  = 8'h24;
  localparam logic [7:0] OFS_PRT1  = 8'h26;
  localparam logic [7:0] OFS_PRT2  = 8'h28;
  localparam logic [7:0] OFS_PRT3  = 8'h2A;
  // Test 0 fields
  localparam int BIT_FORCE = 0;
  localparam int BIT_BIST  = 1;
  localparam int BIT_SRST  = 2;
  // Test 1 fields
  localparam int BIT_STORE_FAIL = 0;
  localparam int BIT_FIFO_FAIL  = 1;
  localparam int BIT_DUAL_FAIL  = 2;
  // Manual register fields
  localparam int BIT_DP1 = 7;
  localparam int BIT_DP0 = 6;
  localparam int BIT_RST = 5;
  localparam int BIT_BUSY_INPUT_BIT = 3;
  localparam int BIT_BUSY_OUTPUT_BIT = 2;
  localparam int BIT_SELECT_INPUT_BIT = 1;
  localparam int BIT_SELECT_OUTPUT_BIT = 0;
  localparam int BIT_IGS = 7;
  localparam int BIT_TGS = 6;
  localparam int BIT_ATN = 5;
  localparam int BIT_IO  = 4;
  localparam int BIT_CD  = 3;
  localparam int BIT_MSG = 2;
  localparam int BIT_ACK = 1;
  localparam int BIT_REQ = 0;
  // Microcode store
  localparam int STORE_DEPTH = 127;
  localparam int WORD_BITS   = 30;
  localparam logic [6:0] ADDR_LAST = 7'h7E;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Default word after reset, value arbitrary
  localparam logic [29:0] STORE_RESET_WORD = 30'h00000000;

  typedef struct packed {
    logic rst, bsy, sel, atn, ack, req, msg, cd, io, dp1, dp0;
    logic [15:0] data;
  } smc_bus_in_type;

  typedef struct packed {
    logic bsy, sel, atn, ack, req, msg, cd, io, dp1, dp0;
    logic [15:0] data;
  } smc_bus_out_type;

  typedef struct packed {
    logic bsy, sel, ini, tgt, dat;
  } smc_bus_oe_type;

  typedef enum logic [1:0] {
    SMC_IDLE = 2'b00,
    SMC_RUN  = 2'b01
  } smc_state_type;
endpackage

/* File: src/smc_manual_ctrl.sv */
/*
  Manual SCSI line control, self-test bits and microcode store byte port.
  Assumes the chip decodes a one-cycle read or write strobe per access, and
  that pad logic resolves line polarity, so bus values here are logical.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_manual_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     reg_cs,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata,
  input  wire logic                     low_level_mode_enable,
  input  wire smc_pkg::smc_bus_in_type  bus_in,
  output smc_pkg::smc_bus_out_type      bus_out,
  output smc_pkg::smc_bus_oe_type       bus_oe,
  output logic                          selftest_start,
  input  wire logic                     selftest_done,
  input  wire logic                     store_fail_in,
  input  wire logic                     fifo_fail_in,
  input  wire logic                     dual_fail_in,
  output logic                          section_soft_reset
);
  logic                  wr_en, rd_en, sreset, port3_acc, io_lvl;
  logic [7:0]            lines0_q, lines0_d, lines1_q, lines1_d;
  logic [7:0]            lo_q, lo_d, hi_q, hi_d, rdata_q, rdata_d;
  logic [6:0]            addr_q, addr_d;
  logic                  force_q, force_d, srst_q, srst_d, start_q, start_d;
  logic [2:0]            fail_q, fail_d;
  smc_pkg::smc_state_type state_q, state_d;
  logic [29:0]           store_q [smc_pkg::STORE_DEPTH];
  logic [29:0]           cur_word;

  assign wr_en     = reg_cs && reg_wr;
  assign rd_en     = reg_cs && reg_rd;
  assign sreset    = srst_q;
  assign port3_acc = (wr_en || rd_en) && reg_addr == smc_pkg::OFS_PRT3;
  assign cur_word  = (addr_q <= smc_pkg::ADDR_LAST) ? store_q[addr_q] : '0;
  // Register side effects land one cycle after the software-reset write
  always_comb begin
    lines0_d = lines0_q;
    lines1_d = lines1_q;
    lo_d    = lo_q;
    hi_d    = hi_q;
    addr_d  = addr_q;
    force_d = force_q;
    srst_d  = 1'b0;
    start_d = 1'b0;
    fail_d  = fail_q;
    state_d = state_q;
    if (wr_en) begin
      unique case (reg_addr)
        smc_pkg::OFS_TEST0: begin
          force_d = reg_wdata[smc_pkg::BIT_FORCE];
          srst_d  = reg_wdata[smc_pkg::BIT_SRST];
          if (reg_wdata[smc_pkg::BIT_BIST] && state_q == smc_pkg::SMC_IDLE) begin
            start_d = 1'b1;
            state_d = smc_pkg::SMC_RUN;
            fail_d  = 3'h0;
          end
        end
        // Input bits 5, 3, 1 have no storage, so writes to them vanish
        smc_pkg::OFS_LINES0: lines0_d = reg_wdata & 8'hC5;
        smc_pkg::OFS_LINES1: lines1_d = reg_wdata;
        smc_pkg::OFS_SCLO: lo_d = reg_wdata;
        smc_pkg::OFS_SCHI: hi_d = reg_wdata;
        smc_pkg::OFS_UADDR: addr_d = reg_wdata[6:0];
        default: ;
      endcase
    end
    if (port3_acc) begin
      addr_d = (addr_q >= smc_pkg::ADDR_LAST) ? smc_pkg::ADDR_RESET : addr_q + 7'h01;
    end
    if (state_q == smc_pkg::SMC_RUN && selftest_done) begin
      state_d = smc_pkg::SMC_IDLE;
      fail_d  = {dual_fail_in, fifo_fail_in, store_fail_in};
    end
    if (sreset) begin
      lines0_d = smc_pkg::BYTE_RESET;
      lines1_d = smc_pkg::BYTE_RESET;
      lo_d    = smc_pkg::BYTE_RESET;
      hi_d    = smc_pkg::BYTE_RESET;
      addr_d  = smc_pkg::ADDR_RESET;
      state_d = smc_pkg::SMC_IDLE;
      force_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lines0_q <= smc_pkg::BYTE_RESET;
      lines1_q <= smc_pkg::BYTE_RESET;
      lo_q    <= smc_pkg::BYTE_RESET;
      hi_q    <= smc_pkg::BYTE_RESET;
      addr_q  <= smc_pkg::ADDR_RESET;
      force_q <= 1'b0;
      srst_q  <= 1'b0;
      start_q <= 1'b0;
      fail_q  <= 3'h0;
      state_q <= smc_pkg::SMC_IDLE;
    end else begin
      lines0_q <= lines0_d;
      lines1_q <= lines1_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
      addr_q  <= addr_d;
      force_q <= force_d;
      srst_q  <= srst_d;
      start_q <= start_d;
      fail_q  <= fail_d;
      state_q <= state_d;
    end
  end

  // Store is flops so reset can preload it without a boot loader
  for (genvar i = 0; i < smc_pkg::STORE_DEPTH; i++) begin : g_store
    logic [29:0] word_d;
    logic        hit;
    always_comb begin
      hit    = wr_en && addr_q == 7'(i);
      word_d = store_q[i];
      if (hit && reg_addr == smc_pkg::OFS_PRT0) word_d[7:0]   = reg_wdata;
      if (hit && reg_addr == smc_pkg::OFS_PRT1) word_d[15:8]  = reg_wdata;
      if (hit && reg_addr == smc_pkg::OFS_PRT2) word_d[23:16] = reg_wdata;
      if (hit && reg_addr == smc_pkg::OFS_PRT3) word_d[29:24] = reg_wdata[5:0];
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        store_q[i] <= smc_pkg::STORE_RESET_WORD;
      end else begin
        store_q[i] <= word_d;
      end
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      unique case (reg_addr)
        smc_pkg::OFS_TEST0: rdata_d = {6'h00, state_q == smc_pkg::SMC_RUN, force_q};
        smc_pkg::OFS_FLAGS: rdata_d = {5'h00, fail_q | {3{force_q}}};
        smc_pkg::OFS_LINES0: rdata_d = {bus_in.dp1, bus_in.dp0, bus_in.rst, 1'b0,
                                        bus_in.bsy, lines0_q[2], bus_in.sel, lines0_q[0]};
        smc_pkg::OFS_LINES1: rdata_d = {lines1_q[7:6], bus_in.atn, bus_in.io,
                                        bus_in.cd, bus_in.msg, bus_in.ack, bus_in.req};
        smc_pkg::OFS_SCLO: rdata_d = bus_in.data[7:0];
        smc_pkg::OFS_SCHI: rdata_d = bus_in.data[15:8];
        smc_pkg::OFS_UADDR: rdata_d = {1'b0, addr_q};
        smc_pkg::OFS_PRT0: rdata_d = cur_word[7:0];
        smc_pkg::OFS_PRT1: rdata_d = cur_word[15:8];
        smc_pkg::OFS_PRT2: rdata_d = cur_word[23:16];
        smc_pkg::OFS_PRT3: rdata_d = {2'b00, cur_word[29:24]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= smc_pkg::BYTE_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Initiator owns data when I/O negated; target when it asserts I/O
  assign io_lvl = (lines1_q[smc_pkg::BIT_IGS] && !bus_in.io) ||
                  (lines1_q[smc_pkg::BIT_TGS] && lines1_q[smc_pkg::BIT_IO]);
  always_comb begin
    bus_oe.bsy = low_level_mode_enable;
    bus_oe.sel = low_level_mode_enable;
    bus_oe.ini = low_level_mode_enable && lines1_q[smc_pkg::BIT_IGS];
    bus_oe.tgt = low_level_mode_enable && lines1_q[smc_pkg::BIT_TGS];
    bus_oe.dat = low_level_mode_enable && io_lvl;
  end

  always_comb begin
    bus_out.bsy  = lines0_q[smc_pkg::BIT_BUSY_OUTPUT_BIT];
    bus_out.sel  = lines0_q[smc_pkg::BIT_SELECT_OUTPUT_BIT];
    bus_out.dp1  = lines0_q[smc_pkg::BIT_DP1];
    bus_out.dp0  = lines0_q[smc_pkg::BIT_DP0];
    bus_out.atn  = lines1_q[smc_pkg::BIT_ATN];
    bus_out.ack  = lines1_q[smc_pkg::BIT_ACK];
    bus_out.req  = lines1_q[smc_pkg::BIT_REQ];
    bus_out.msg  = lines1_q[smc_pkg::BIT_MSG];
    bus_out.cd   = lines1_q[smc_pkg::BIT_CD];
    bus_out.io   = lines1_q[smc_pkg::BIT_IO];
    bus_out.data = {hi_q, lo_q};
  end

  assign reg_rdata          = rdata_q;
  assign selftest_start     = start_q;
  assign section_soft_reset = srst_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bist_req;
    wr_en && reg_addr == smc_pkg::OFS_TEST0 && reg_wdata[smc_pkg::BIT_BIST] &&
    state_q == smc_pkg::SMC_IDLE && !sreset;
  endsequence
  sequence s_bist_launch;
    selftest_start && state_q == smc_pkg::SMC_RUN;
  endsequence
  property p_bist_start;
    s_bist_req |=> s_bist_launch;
  endproperty
  a_bist_start: assert property (p_bist_start) else $error("self-test not launched");
  property p_bist_clear;
    state_q == smc_pkg::SMC_RUN && selftest_done && !sreset |=> state_q == smc_pkg::SMC_IDLE;
  endproperty
  a_bist_clear: assert property (p_bist_clear) else $error("start bit stuck");
  property p_fail_force;
    force_q && rd_en && reg_addr == smc_pkg::OFS_FLAGS |=> reg_rdata[2:0] == 3'h7;
  endproperty
  a_fail_force: assert property (p_fail_force) else $error("fail flags not forced");
  property p_rst_read;
    rd_en && reg_addr == smc_pkg::OFS_LINES0 |=> reg_rdata[5] == $past(bus_in.rst);
  endproperty
  a_rst_read: assert property (p_rst_read) else $error("reset line misread");
  property p_addr_inc;
    port3_acc && addr_q < smc_pkg::ADDR_LAST && !sreset |=> addr_q == $past(addr_q) + 7'h01;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");
  property p_addr_wrap;
    port3_acc && addr_q == smc_pkg::ADDR_LAST |=> addr_q == 7'h00;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap");
  property p_addr_hold;
    (wr_en || rd_en) && (reg_addr == smc_pkg::OFS_PRT0 || reg_addr == smc_pkg::OFS_PRT1 ||
    reg_addr == smc_pkg::OFS_PRT2) && !sreset |=> $stable(addr_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_atn_drive;
    wr_en && reg_addr == smc_pkg::OFS_LINES1 && reg_wdata[7] && reg_wdata[5] && !sreset
    ##1 low_level_mode_enable |-> bus_oe.ini && bus_out.atn;
  endproperty
  a_atn_drive: assert property (p_atn_drive) else $error("ATN not driven");
  property p_no_target;
    !lines1_q[smc_pkg::BIT_TGS] |-> !bus_oe.tgt;
  endproperty
  a_no_target: assert property (p_no_target) else $error("target lines driven");
  property p_bsy_drive;
    wr_en && reg_addr == smc_pkg::OFS_LINES0 && !sreset ##1 low_level_mode_enable
    |-> bus_oe.bsy && bus_out.bsy == $past(reg_wdata[2]);
  endproperty
  a_bsy_drive: assert property (p_bsy_drive) else $error("BSY drive wrong");
  property p_soft_reset;
    sreset |=> lines1_q == 8'h00 && addr_q == 7'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored");

  // Target role drives its group with the written values
  property p_tgt_drive;
    wr_en && reg_addr == smc_pkg::OFS_LINES1 && reg_wdata[6] && !sreset
    ##1 low_level_mode_enable |-> bus_oe.tgt && bus_out.req == $past(reg_wdata[0]);
  endproperty
  a_tgt_drive: assert property (p_tgt_drive) else $error("target group not driven");

  // Target that asserts I/O owns the data lines
  property p_data_drive;
    wr_en && reg_addr == smc_pkg::OFS_LINES1 && reg_wdata[6] && reg_wdata[4] && !sreset
    ##1 low_level_mode_enable |-> bus_oe.dat;
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("data lines not driven");

  // Line inputs have no storage behind them
  property p_inputs_ignored;
    wr_en && reg_addr == smc_pkg::OFS_LINES0 && !sreset
    |=> lines0_q[5] == 1'b0 && lines0_q[3] == 1'b0 && lines0_q[1] == 1'b0;
  endproperty
  a_inputs_ignored: assert property (p_inputs_ignored) else $error("input bit stored");

  // Mode off releases every manual driver
  property p_mode_off;
    !low_level_mode_enable |-> !bus_oe.bsy && !bus_oe.sel && !bus_oe.ini &&
    !bus_oe.tgt && !bus_oe.dat;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("driver on with mode off");

  // Launch is a single pulse so testers start once
  property p_start_pulse;
    selftest_start |=> !selftest_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
endmodule
`default_nettype wire

/* File: bench/smc_far_end_model.sv */
/*
  Far side of the manual control block: the other bus party and the
  external self-test engines. Assumes logical line levels, wired-OR.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_far_end_model (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire smc_pkg::smc_bus_in_type far_lines,
  input  wire smc_pkg::smc_bus_out_type bus_out,
  input  wire smc_pkg::smc_bus_oe_type bus_oe,
  output smc_pkg::smc_bus_in_type      bus_in,
  input  wire logic                    selftest_start,
  output logic                         selftest_done,
  input  wire logic [2:0]              fail_pattern,
  output logic [2:0]                   fail_out
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  // Line is asserted if either party asserts it
  always_comb begin
    bus_in = far_lines;
    bus_in.bsy = far_lines.bsy | (bus_oe.bsy & bus_out.bsy);
    bus_in.sel = far_lines.sel | (bus_oe.sel & bus_out.sel);
    bus_in.atn = far_lines.atn | (bus_oe.ini & bus_out.atn);
    bus_in.ack = far_lines.ack | (bus_oe.ini & bus_out.ack);
    bus_in.req = far_lines.req | (bus_oe.tgt & bus_out.req);
    bus_in.msg = far_lines.msg | (bus_oe.tgt & bus_out.msg);
    bus_in.cd = far_lines.cd | (bus_oe.tgt & bus_out.cd);
    bus_in.io = far_lines.io | (bus_oe.tgt & bus_out.io);
    bus_in.dp1 = far_lines.dp1 | (bus_oe.dat & bus_out.dp1);
    bus_in.dp0 = far_lines.dp0 | (bus_oe.dat & bus_out.dp0);
    bus_in.data = far_lines.data | (bus_oe.dat ? bus_out.data : 16'h0000);
  end
  // Tests take five cycles, slow enough to poll the running bit
  always_comb begin
    cnt_d = cnt_q;
    if (selftest_start) begin
      cnt_d = 3'h5;
    end else if (cnt_q != 3'h0) begin
      cnt_d = cnt_q - 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    cnt_q <= rst_n ? cnt_d : 3'h0;
  end
  assign selftest_done = (cnt_q == 3'h1);
  assign fail_out = fail_pattern;
endmodule
`default_nettype wire

/* File: bench/smc_manual_ctrl_tb.sv */
/*
  Register-level bench for the manual control block.
  Assumes the far end model resolves the bus lines.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_manual_ctrl_tb;
  logic clk = 1'b0, rst_n = 1'b0, cs = 1'b0, wr_s = 1'b0, rd_s = 1'b0, mode = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] fails = 3'h5, fail_o;
  logic start, done, sreset;
  int mismatches = 0, comparisons = 0, w, i;
  smc_pkg::smc_bus_in_type far = '0, bin;
  smc_pkg::smc_bus_out_type bout;
  smc_pkg::smc_bus_oe_type boe;
  always #25 clk = ~clk;
  smc_manual_ctrl smc_manual_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_cs(cs),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .low_level_mode_enable(mode), .bus_in(bin), .bus_out(bout),
    .bus_oe(boe), .selftest_start(start), .selftest_done(done),
    .store_fail_in(fail_o[0]), .fifo_fail_in(fail_o[1]), .dual_fail_in(fail_o[2]),
    .section_soft_reset(sreset));
  smc_far_end_model smc_far_end_model_inst (.clk(clk), .rst_n(rst_n), .far_lines(far),
    .bus_out(bout), .bus_oe(boe), .bus_in(bin), .selftest_start(start),
    .selftest_done(done), .fail_pattern(fails), .fail_out(fail_o));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cs <= 1'b1; wr_s <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    cs <= 1'b0; wr_s <= 1'b0;
    #1;
  endtask
  // Read data lands at the taking edge and is checked 1 ns after it
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    cs <= 1'b1; rd_s <= 1'b1; addr <= a;
    @(posedge clk);
    cs <= 1'b0; rd_s <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata & m});
  endtask
  task automatic lines(input logic [15:0] d, input logic io, input logic [2:0] rbs);
    @(posedge clk);
    far.data <= d; far.io <= io; {far.rst, far.bsy, far.sel} <= rbs;
    #1;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(smc_pkg::OFS_LINES1, 8'hFF, 8'h00);
    chk("oe", 16'h0000, {11'h000, boe});
    rd(8'h40, 8'hFF, 8'h00);
    // Input bits follow the lines, writes to them ignored
    lines(16'h0000, 1'b0, 3'b111);
    rd(smc_pkg::OFS_LINES0, 8'h2A, 8'h2A);
    rd(smc_pkg::OFS_LINES0, 8'h2A, 8'h2A);
    wr(smc_pkg::OFS_LINES0, 8'hFF);
    chk("bsy oe off", 16'h0000, {15'h0000, boe.bsy});
    lines(16'h0000, 1'b0, 3'b000);
    rd(smc_pkg::OFS_LINES0, 8'h2A, 8'h00);
    @(posedge clk) mode <= 1'b1;
    #1 chk("bsy sel", 16'h000F, {12'h000, boe.bsy, boe.sel, bout.bsy, bout.sel});
    // Role gating of the control groups
    wr(smc_pkg::OFS_LINES1, 8'hA2);
    chk("ini", 16'h000B, {12'h000, boe.ini, boe.tgt, bout.atn, bout.ack});
    rd(smc_pkg::OFS_LINES1, 8'hFF, 8'hA2);
    wr(smc_pkg::OFS_LINES1, 8'h5D);
    chk("tgt", 16'h0002, {14'h0000, boe.tgt, boe.ini});
    rd(smc_pkg::OFS_LINES1, 8'hFF, 8'h5D);
    wr(smc_pkg::OFS_LINES1, 8'h1D);
    rd(smc_pkg::OFS_LINES1, 8'hFF, 8'h00);
    // Data and parity ownership
    wr(smc_pkg::OFS_LINES1, 8'h50);
    wr(smc_pkg::OFS_SCLO, 8'h5A);
    wr(smc_pkg::OFS_SCHI, 8'hC3);
    wr(smc_pkg::OFS_LINES0, 8'hC0);
    chk("dat tgt", 16'hC35A, boe.dat ? bout.data : 16'h0000);
    rd(smc_pkg::OFS_LINES0, 8'hC0, 8'hC0);
    rd(smc_pkg::OFS_SCLO, 8'hFF, 8'h5A);
    wr(smc_pkg::OFS_LINES1, 8'h80);
    chk("dat ini", 16'h0001, {15'h0000, boe.dat});
    lines(16'h1234, 1'b1, 3'b000);
    chk("dat ini in", 16'h0000, {15'h0000, boe.dat});
    rd(smc_pkg::OFS_SCLO, 8'hFF, 8'h34);
    rd(smc_pkg::OFS_SCHI, 8'hFF, 8'h12);
    lines(16'h0000, 1'b0, 3'b000);
    @(posedge clk) mode <= 1'b0;
    #1 chk("dat mode off", 16'h0000, {15'h0000, boe.dat});
    // Microcode store port
    rd(smc_pkg::OFS_PRT0, 8'hFF, 8'h00);
    wr(smc_pkg::OFS_UADDR, 8'h00);
    for (w = 0; w < 2; w++) begin
      wr(smc_pkg::OFS_PRT0, 8'hC1 + 8'(w));
      wr(smc_pkg::OFS_PRT1, 8'h82);
      wr(smc_pkg::OFS_PRT2, 8'h43);
      rd(smc_pkg::OFS_UADDR, 8'hFF, 8'(w));
      wr(smc_pkg::OFS_PRT3, 8'hFF);
      rd(smc_pkg::OFS_UADDR, 8'hFF, 8'(w + 1));
    end
    wr(smc_pkg::OFS_UADDR, 8'h00);
    for (w = 0; w < 2; w++) begin
      rd(smc_pkg::OFS_PRT0, 8'hFF, 8'hC1 + 8'(w));
      rd(smc_pkg::OFS_PRT1, 8'hFF, 8'h82);
      rd(smc_pkg::OFS_PRT2, 8'hFF, 8'h43);
      rd(smc_pkg::OFS_PRT3, 8'hFF, 8'h3F);
    end
    rd(smc_pkg::OFS_UADDR, 8'hFF, 8'h02);
    wr(smc_pkg::OFS_UADDR, 8'h7E);
    wr(smc_pkg::OFS_PRT3, 8'h00);
    rd(smc_pkg::OFS_UADDR, 8'hFF, 8'h00);
    // Self-test, then fail-check once it has run
    wr(smc_pkg::OFS_TEST0, 8'h02);
    chk("start", 16'h0001, {15'h0000, start});
    rd(smc_pkg::OFS_TEST0, 8'h02, 8'h02);
    i = 0;
    while (rdata[1] !== 1'b0) begin
      if (i++ == 20) begin
        mismatches++;
        report_and_stop();
      end
      rd(smc_pkg::OFS_TEST0, 8'h00, 8'h00);
    end
    rd(smc_pkg::OFS_FLAGS, 8'h07, 8'h05);
    wr(smc_pkg::OFS_TEST0, 8'h01);
    rd(smc_pkg::OFS_FLAGS, 8'h07, 8'h07);
    wr(smc_pkg::OFS_TEST0, 8'h00);
    rd(smc_pkg::OFS_FLAGS, 8'h07, 8'h05);
    // Software reset of the section
    wr(smc_pkg::OFS_LINES1, 8'hC0);
    wr(smc_pkg::OFS_UADDR, 8'h11);
    wr(smc_pkg::OFS_TEST0, 8'h04);
    chk("soft reset", 16'h0001, {15'h0000, sreset});
    repeat (2) @(posedge clk);
    rd(smc_pkg::OFS_LINES1, 8'hFF, 8'h00);
    rd(smc_pkg::OFS_UADDR, 8'hFF, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
